// file: rtl/led_pump_ctrl.sv
// Charge pump gain selection, group enables and brightness registers
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/100ps
`include "led_pump_params.svh"
module led_pump_ctrl #(
    parameter int unsigned TICK_CYCLES = `LP_DLY_TICK_US * `LP_CLK_MHZ
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic HARDWARE_ENABLE_RESET_PIN,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    input wire led_pump_pkg::sink_flags_s SINK_LOW,
    input wire logic TEMP_HOT,
    input wire logic TEMP_COOL,
    output led_pump_pkg::sink_flags_s SINK_ENABLE,
    output logic [4:0] MAIN_LEVEL,
    output logic [2:0] SECONDARY_LEVEL,
    output logic [2:0] INDICATOR_LEVEL,
    output logic PUMP_ENABLE,
    output logic PUMP_GAIN_HIGH,
    output logic THERMAL_SHUTDOWN
);
    // ****************************************
    // Constants and checks
    // ****************************************
    localparam int PIN_W = 3 + $bits(led_pump_pkg::sink_flags_s);
    localparam led_pump_pkg::core_state_s ST_DEFAULT = '{
        gp: `LP_RST_GP,
        lvl_a: `LP_RST_LVL_A,
        lvl_b: `LP_RST_LVL_B,
        lvl_c: `LP_RST_LVL_C,
        ramp: `LP_RST_RAMP,
        vfdly: `LP_RST_VFDLY,
        rdata: 8'h00,
        gain: led_pump_pkg::GAIN_PASS,
        shut: 1'b0
    };

    if (TICK_CYCLES < 2) begin : g_bad_tick
        $error("led_pump_ctrl: TICK_CYCLES must be at least 2");
    end

    // ****************************************
    // Pin synchronisation
    // ****************************************
    logic [PIN_W-1:0] pins_s;
    logic enable_s;
    logic hot_s;
    logic cool_s;
    led_pump_pkg::sink_flags_s low_s;

    pin_sync #(
        .W(PIN_W)
    ) u_sync (
        .clk(CLK),
        .rst(RST),
        .d({HARDWARE_ENABLE_RESET_PIN, TEMP_HOT, TEMP_COOL, SINK_LOW}),
        .q(pins_s)
    );

    assign {enable_s, hot_s, cool_s, low_s} = pins_s;

    // ****************************************
    // Group decode and headroom monitor
    // ****************************************
    led_pump_pkg::core_state_s st_r;
    led_pump_pkg::core_state_s st_nxt;
    led_pump_pkg::sink_flags_s mask;
    logic en_main;
    logic en_sec;
    logic en_ind;
    logic low_any;
    logic dly_run;
    logic dly_clear;
    logic dly_expired;

    assign en_main = st_r.gp[`LP_GP_EN_MAIN]; // R14
    assign en_sec = st_r.gp[`LP_GP_EN_SEC]; // R14
    assign en_ind = st_r.gp[`LP_GP_EN_IND]; // R14

    // D53 and D62 join the main group when configured there and the
    // secondary group otherwise; a shut-down sink is never driven.
    always_comb begin
        mask.main[3:0] = {4{en_main}};
        mask.main[4] = !st_r.gp[`LP_GP_SD53] &&
            (st_r.gp[`LP_GP_53A] ? en_main : en_sec);
        mask.main[5] = !st_r.gp[`LP_GP_SD62] &&
            (st_r.gp[`LP_GP_62A] ? en_main : en_sec);
        mask.secondary = {3{en_sec}};
        mask.indicator = en_ind;
    end

    // Any enabled sink at threshold means the weakest LED lacks headroom
    assign low_any = |(low_s & mask); // R3 R4

    assign dly_run = st_r.gain == led_pump_pkg::GAIN_PASS && low_any &&
        !st_r.shut;
    assign dly_clear = REG_WR || !enable_s; // R15

    gain_delay_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timer (
        .clk(CLK),
        .rst(RST),
        .run(dly_run),
        .clear(dly_clear),
        .sel(st_r.vfdly[1:0]),
        .expired(dly_expired)
    );

    // ****************************************
    // Register file, gain and thermal state
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = 8'h00;
        if (!enable_s) begin
            st_nxt = ST_DEFAULT; // R7
        end else begin
            // Serial writes are the only path to enables and levels
            if (REG_WR) begin // R11 R9
                unique case (REG_ADDR)
                    `LP_ADDR_GP: st_nxt.gp = {1'b0, REG_WDATA[6:0]}; // R14
                    `LP_ADDR_LVL_A: st_nxt.lvl_a = {3'b111, REG_WDATA[4:0]}; // R10
                    `LP_ADDR_LVL_B: st_nxt.lvl_b = {5'h1f, REG_WDATA[2:0]}; // R10
                    `LP_ADDR_LVL_C: st_nxt.lvl_c = {5'h1f, REG_WDATA[2:0]}; // R10
                    `LP_ADDR_RAMP: st_nxt.ramp = REG_WDATA;
                    `LP_ADDR_VFDLY: st_nxt.vfdly = {6'h3f, REG_WDATA[1:0]}; // R6
                    default: ;
                endcase
            end
            if (REG_RD) begin
                unique case (REG_ADDR)
                    `LP_ADDR_GP: st_nxt.rdata = st_r.gp;
                    `LP_ADDR_LVL_A: st_nxt.rdata = st_r.lvl_a;
                    `LP_ADDR_LVL_B: st_nxt.rdata = st_r.lvl_b;
                    `LP_ADDR_LVL_C: st_nxt.rdata = st_r.lvl_c;
                    `LP_ADDR_RAMP: st_nxt.rdata = st_r.ramp;
                    `LP_ADDR_VFDLY: st_nxt.rdata = st_r.vfdly;
                    `LP_ADDR_STATUS: st_nxt.rdata = {5'h00, low_any, st_r.shut,
                        st_r.gain == led_pump_pkg::GAIN_3_2};
                    default: st_nxt.rdata = 8'h00;
                endcase
            end
            // Hysteresis: the hot comparator wins if both are seen at once
            if (hot_s) begin
                st_nxt.shut = 1'b1; // R12
            end else if (cool_s) begin
                st_nxt.shut = 1'b0; // R12
            end
            unique case (st_r.gain)
                led_pump_pkg::GAIN_PASS: begin
                    // The timer output lags one cycle, so the headroom
                    // condition must still stand when the gain moves
                    if (dly_expired && dly_run && !REG_WR) begin
                        st_nxt.gain = led_pump_pkg::GAIN_3_2; // R1 R5
                    end
                end
                led_pump_pkg::GAIN_3_2: begin
                    // Re-evaluation uses the enables in force before the
                    // write; a write that changes them is seen next time.
                    if (REG_WR) begin
                        st_nxt.gain = low_any ? led_pump_pkg::GAIN_3_2
                            : led_pump_pkg::GAIN_PASS; // R2
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st_r <= ST_DEFAULT; // R15
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign REG_RDATA = st_r.rdata;
    assign SINK_ENABLE = st_r.shut ? '0 : mask; // R12
    assign MAIN_LEVEL = st_r.lvl_a[4:0]; // R10
    assign SECONDARY_LEVEL = st_r.lvl_b[2:0]; // R10
    assign INDICATOR_LEVEL = st_r.lvl_c[2:0]; // R10
    assign PUMP_ENABLE = |mask && !st_r.shut;
    assign PUMP_GAIN_HIGH = st_r.gain == led_pump_pkg::GAIN_3_2;
    assign THERMAL_SHUTDOWN = st_r.shut;

    // ****************************************
    // Assertions
    // ****************************************
    // Length of the current unbroken run of the delay timer
    logic [31:0] run_len;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            run_len <= 32'h0000_0000;
        end else if (!dly_run || dly_clear) begin
            run_len <= 32'h0000_0000;
        end else if (run_len != 32'hffff_ffff) begin
            run_len <= run_len + 32'h0000_0001;
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    property p_gain_rise_cause;
        $rose(PUMP_GAIN_HIGH) |-> $past(dly_expired) && $past(low_any);
    endproperty
    a_gain_rise_cause: assert property (p_gain_rise_cause) // R1
        else $error("Gain rose without an expired headroom delay");

    property p_gain_hold;
        PUMP_GAIN_HIGH && enable_s && !REG_WR |=> PUMP_GAIN_HIGH;
    endproperty
    a_gain_hold: assert property (p_gain_hold) // R2
        else $error("Gain 3/2 dropped without a register write");

    property p_gain_reeval;
        PUMP_GAIN_HIGH && enable_s && REG_WR && !low_any |=> !PUMP_GAIN_HIGH;
    endproperty
    a_gain_reeval: assert property (p_gain_reeval) // R2
        else $error("Write did not return the pump to pass mode");

    property p_disabled_ignored;
        !PUMP_GAIN_HIGH && !(|(low_s & mask)) |=> !PUMP_GAIN_HIGH;
    endproperty
    a_disabled_ignored: assert property (p_disabled_ignored) // R3
        else $error("Gain changed with no enabled sink low");

    property p_weakest_sink;
        en_main && en_sec && en_ind && low_s.indicator |-> low_any;
    endproperty
    a_weakest_sink: assert property (p_weakest_sink) // R4
        else $error("A low enabled sink was not seen by the monitor");

    property p_dip_filter;
        $rose(PUMP_GAIN_HIGH) |-> $past(run_len) >= TICK_CYCLES;
    endproperty
    a_dip_filter: assert property (p_dip_filter) // R5
        else $error("Gain changed before one full delay tick");

    property p_delay_select;
        enable_s && REG_WR && REG_ADDR == `LP_ADDR_VFDLY
            |=> st_r.vfdly[1:0] == $past(REG_WDATA[1:0]);
    endproperty
    a_delay_select: assert property (p_delay_select) // R6
        else $error("Delay range select not taken from the write");

    property p_pin_reset;
        !enable_s |=> SINK_ENABLE == '0 && !PUMP_ENABLE && !PUMP_GAIN_HIGH
            && st_r.lvl_a == `LP_RST_LVL_A && st_r.vfdly == `LP_RST_VFDLY;
    endproperty
    a_pin_reset: assert property (p_pin_reset) // R7 R15
        else $error("Enable pin low did not restore defaults");

    property p_main_level;
        enable_s && REG_WR && REG_ADDR == `LP_ADDR_LVL_A
            |=> MAIN_LEVEL == $past(REG_WDATA[4:0]);
    endproperty
    a_main_level: assert property (p_main_level) // R10
        else $error("Main level not updated by its write");

    property p_write_only;
        enable_s && !REG_WR |=> $stable(st_r.gp) && $stable(MAIN_LEVEL);
    endproperty
    a_write_only: assert property (p_write_only) // R11
        else $error("Enables or level changed without a write");

    property p_thermal;
        enable_s && hot_s |=> THERMAL_SHUTDOWN ##0 SINK_ENABLE == '0;
    endproperty
    a_thermal: assert property (p_thermal) // R12
        else $error("Over-temperature did not shut the outputs");

    property p_enable_bits;
        enable_s && REG_WR && REG_ADDR == `LP_ADDR_GP
            |=> {en_ind, en_sec, en_main} == $past(REG_WDATA[2:0]);
    endproperty
    a_enable_bits: assert property (p_enable_bits) // R14
        else $error("Group enables not at bits 0 to 2");

    property p_read_timing;
        enable_s && REG_RD && REG_ADDR == `LP_ADDR_GP |=> REG_RDATA == $past(st_r.gp);
    endproperty
    a_read_timing: assert property (p_read_timing)
        else $error("Read data not presented one cycle after the strobe");

    c_gain_up: cover property ($rose(PUMP_GAIN_HIGH));
    c_gain_back: cover property (PUMP_GAIN_HIGH && REG_WR ##1 !PUMP_GAIN_HIGH);
    c_thermal: cover property ($rose(THERMAL_SHUTDOWN) ##[1:200] !THERMAL_SHUTDOWN);
    c_all_groups: cover property (en_main && en_sec && en_ind && low_any);
    c_pin_low: cover property ($fell(enable_s));

    property p_thermal_resume;
        enable_s && !hot_s && cool_s |=> !THERMAL_SHUTDOWN;
    endproperty
    a_thermal_resume: assert property (p_thermal_resume) // R12
        else $error("Cool comparator did not end the shutdown");

    property p_write_restart;
        REG_WR |=> !dly_expired;
    endproperty
    a_write_restart: assert property (p_write_restart) // R5
        else $error("A write did not restart the gain delay");

    property p_shut_no_gain;
        THERMAL_SHUTDOWN && !PUMP_GAIN_HIGH |=> !PUMP_GAIN_HIGH;
    endproperty
    a_shut_no_gain: assert property (p_shut_no_gain) // R12
        else $error("Gain rose during thermal shutdown");

    property p_reset_start;
        $rose(enable_s) |-> !PUMP_GAIN_HIGH && !dly_expired;
    endproperty
    a_reset_start: assert property (p_reset_start) // R15
        else $error("Start after reset not at gain 1 with a clear timer");

    property p_rdata_idle;
        !REG_RD |=> REG_RDATA == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("Read data present without a read strobe");

    property p_sec_level;
        enable_s && REG_WR && REG_ADDR == `LP_ADDR_LVL_B
            |=> SECONDARY_LEVEL == $past(REG_WDATA[2:0]);
    endproperty
    a_sec_level: assert property (p_sec_level) // R10
        else $error("Secondary level not updated by its write");

    property p_ind_level;
        enable_s && REG_WR && REG_ADDR == `LP_ADDR_LVL_C
            |=> INDICATOR_LEVEL == $past(REG_WDATA[2:0]);
    endproperty
    a_ind_level: assert property (p_ind_level) // R10
        else $error("Indicator level not updated by its write");
endmodule

// file: common/led_pump_params.svh
// Constants for the LED charge pump gain and enable controller
// Function
// (R1) Pump starts in pass mode; moves to 3/2 when an enabled sink nears 150mV.
// (R2) Gain 3/2 holds until a register write, which re-evaluates the gain.
// (R3) Only sinks of enabled groups take part in the gain decision.
// (R4) With all groups on, the weakest-headroom sink decides the gain.
// (R5) Transition delay ignores dips shorter than 3 to 6 ms by default.
// (R6) Four delay ranges are chosen by the monitor delay register.
// (R7) Enable pin low resets all control registers and disables outputs.
// (R8) Host keeps the enable pin high during normal operation.
// (R9) Serial data changes only while serial clock is low.
// (R10) Main group has 32 levels, secondary and indicator 8 levels each.
// (R11) Enables and brightness change only through serial-bus writes.
// (R12) Shut down at about 160 C, resume at about 155 C.
// (R13) Host drives serial clock and data free of glitches.
// (R14) Three group enables sit at bits 0, 1, 2 of register 10h.
// (R15) After reset gain is 1 and the delay timer is cleared.
`ifndef LED_PUMP_PARAMS_SVH
`define LED_PUMP_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define LP_ADDR_GP 8'h10
`define LP_ADDR_RAMP 8'h20
`define LP_ADDR_VFDLY 8'h60
`define LP_ADDR_STATUS 8'h70
`define LP_ADDR_LVL_A 8'ha0
`define LP_ADDR_LVL_B 8'hb0
`define LP_ADDR_LVL_C 8'hc0

// ****************************************
// Field positions
// ****************************************
`define LP_GP_EN_MAIN 0
`define LP_GP_EN_SEC 1
`define LP_GP_EN_IND 2
`define LP_GP_SD53 3
`define LP_GP_SD62 4
`define LP_GP_53A 5
`define LP_GP_62A 6

// ****************************************
// Reset values
// ****************************************
`define LP_RST_GP 8'h00
`define LP_RST_LVL_A 8'he0
`define LP_RST_LVL_B 8'hf8
`define LP_RST_LVL_C 8'hf8
`define LP_RST_RAMP 8'hf0
`define LP_RST_VFDLY 8'hfc

// ****************************************
// Timing
// ****************************************
`define LP_CLK_MHZ 100
`define LP_DLY_TICK_US 3000
`define LP_DLY_TICKS_MIN 2

`endif

// file: common/led_pump_pkg.sv
// Types shared by the LED charge pump controller
package led_pump_pkg;

    typedef enum logic {GAIN_PASS, GAIN_3_2} gain_e;

    // One flag per current sink, grouped as the LED groups are
    typedef struct packed {
        logic [5:0] main;
        logic [2:0] secondary;
        logic indicator;
    } sink_flags_s;

    typedef struct packed {
        logic [7:0] gp;
        logic [7:0] lvl_a;
        logic [7:0] lvl_b;
        logic [7:0] lvl_c;
        logic [7:0] ramp;
        logic [7:0] vfdly;
        logic [7:0] rdata;
        gain_e gain;
        logic shut;
    } core_state_s;

endpackage

// file: rtl/pin_sync.sv
// Two-stage synchroniser for asynchronous input pins
`timescale 1ns/100ps
module pin_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } sync_s;

    sync_s st_r;
    sync_s st_nxt;

    if (W < 1) begin : g_bad_width
        $error("pin_sync: width must be at least 1");
    end

    always_comb begin
        st_nxt.meta = d;
        st_nxt.sync = st_r.meta;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.sync;
endmodule

// file: rtl/gain_delay_timer.sv
// Gain transition delay: low headroom must persist for a number of ticks
`timescale 1ns/100ps
`include "led_pump_params.svh"
module gain_delay_timer #(
    parameter int unsigned TICK_CYCLES = `LP_DLY_TICK_US * `LP_CLK_MHZ
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic clear,
    input wire logic [1:0] sel,
    output logic expired
);
    localparam int PW = $clog2(TICK_CYCLES);

    typedef struct packed {
        logic [PW-1:0] presc;
        logic [4:0] ticks;
        logic expired;
    } tmr_s;

    tmr_s st_r;
    tmr_s st_nxt;
    logic tick;
    logic [4:0] need;

    if (TICK_CYCLES < 2) begin : g_bad_tick
        $error("gain_delay_timer: TICK_CYCLES must be at least 2");
    end

    // Prescaler runs free, so the first tick lands anywhere in the first
    // period: the filter time is between need-1 and need ticks.
    always_comb begin
        need = 5'(`LP_DLY_TICKS_MIN) << sel; // R6
        tick = st_r.presc == PW'(TICK_CYCLES - 1);
        st_nxt = st_r;
        st_nxt.presc = tick ? '0 : st_r.presc + 1'b1;
        if (!run || clear) begin
            st_nxt.ticks = '0; // R5
        end else if (tick && st_r.ticks < need) begin
            st_nxt.ticks = st_r.ticks + 5'h01;
        end
        st_nxt.expired = run && !clear && st_nxt.ticks >= need; // R5
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign expired = st_r.expired;
endmodule

// file: bench/led_pump_host.sv
// Host controller model driving the decoded register port and the enable pin
`timescale 1ns/100ps
module led_pump_host (
    input wire logic clk,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata,
    output logic hw_en
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        hw_en = 1'b1;
    end

    // ****************************************
    // Register cycles
    // ****************************************
    // Address and data stay put through the strobe cycle; one clean pulse each
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        // Released lines show the inverse so a stale value never passes
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(negedge clk);
        d = reg_rdata;
    endtask

    task automatic set_pin(input logic v);
        @(posedge clk);
        hw_en <= v;
    endtask
endmodule

// file: bench/led_pump_ctrl_tb_top.sv
// Self-checking bench for the charge pump gain and enable controller
`timescale 1ns/100ps
`include "led_pump_params.svh"
module led_pump_ctrl_tb_top;
    localparam int TICK = 20;
    logic CLK;
    logic RST;
    logic hw_en;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    led_pump_pkg::sink_flags_s sink_low;
    logic temp_hot;
    logic temp_cool;
    led_pump_pkg::sink_flags_s sink_en;
    logic [4:0] main_lvl;
    logic [2:0] sec_lvl;
    logic [2:0] ind_lvl;
    logic pump_en;
    logic gain_hi;
    logic shut;
    int err_count = 0;
    int check_count = 0;
    int cyc = 0;

    led_pump_host i_led_pump_host (.clk(CLK), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .hw_en(hw_en));

    led_pump_ctrl #(.TICK_CYCLES(TICK)) i_led_pump_ctrl (.CLK(CLK), .RST(RST),
        .HARDWARE_ENABLE_RESET_PIN(hw_en), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .SINK_LOW(sink_low),
        .TEMP_HOT(temp_hot), .TEMP_COOL(temp_cool), .SINK_ENABLE(sink_en),
        .MAIN_LEVEL(main_lvl), .SECONDARY_LEVEL(sec_lvl), .INDICATOR_LEVEL(ind_lvl),
        .PUMP_ENABLE(pump_en), .PUMP_GAIN_HIGH(gain_hi), .THERMAL_SHUTDOWN(shut));

    always #5 CLK = ~CLK;

    // ****************************************
    // Reporting
    // ****************************************
    task automatic chk(input string name, input logic [9:0] seen, input logic [9:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Generous ceiling: the whole sequence needs about a thousand cycles
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            test_done();
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic reset_check();
        logic [7:0] ra [7] = '{`LP_ADDR_GP, `LP_ADDR_LVL_A, `LP_ADDR_LVL_B, `LP_ADDR_LVL_C,
            `LP_ADDR_RAMP, `LP_ADDR_VFDLY, 8'h33};
        logic [7:0] re [7] = '{`LP_RST_GP, `LP_RST_LVL_A, `LP_RST_LVL_B, `LP_RST_LVL_C,
            `LP_RST_RAMP, `LP_RST_VFDLY, 8'h00};
        logic [7:0] d;
        for (int i = 0; i < 7; i++) begin
            i_led_pump_host.rd(ra[i], d);
            chk("reset_reg", 10'(d), 10'(re[i]));
        end
        chk("reset_gain", 10'(gain_hi), 10'h000);
        chk("reset_pump", 10'(pump_en), 10'h000);
        $display("reset_check done");
    endtask

    task automatic enable_check();
        logic [7:0] gv [6] = '{8'h01, 8'h02, 8'h04, 8'h07, 8'h0a, 8'h00};
        logic [9:0] ge [6] = '{10'h0f0, 10'h30e, 10'h001, 10'h3ff, 10'h20e, 10'h000};
        for (int i = 0; i < 6; i++) begin
            i_led_pump_host.wr(`LP_ADDR_GP, gv[i]);
            @(negedge CLK);
            chk("sink_enable", sink_en, ge[i]);
            chk("pump_enable", 10'(pump_en), 10'(gv[i] != 8'h00));
        end
        $display("enable_check done");
    endtask

    task automatic level_check();
        logic [7:0] la [3] = '{`LP_ADDR_LVL_A, `LP_ADDR_LVL_B, `LP_ADDR_LVL_C};
        logic [7:0] lv [3] = '{8'h1f, 8'h05, 8'h02};
        logic [7:0] lr [3] = '{8'hff, 8'hfd, 8'hfa};
        logic [7:0] d;
        for (int i = 0; i < 3; i++) begin
            i_led_pump_host.wr(la[i], lv[i]);
            i_led_pump_host.rd(la[i], d);
            chk("level_read", 10'(d), 10'(lr[i]));
        end
        chk("main_level", 10'(main_lvl), 10'h01f);
        chk("sec_level", 10'(sec_lvl), 10'h005);
        chk("ind_level", 10'(ind_lvl), 10'h002);
        $display("level_check done");
    endtask

    task automatic gain_check();
        int n;
        int t;
        logic [7:0] d;
        // Sinks of disabled groups sit low for well over the longest default delay
        i_led_pump_host.wr(`LP_ADDR_GP, 8'h01);
        @(posedge CLK);
        sink_low <= 10'h00f;
        repeat (4 * TICK) @(posedge CLK);
        @(negedge CLK);
        chk("gain_disabled", 10'(gain_hi), 10'h000);
        for (int s = 0; s < 4; s++) begin
            n = 2 << s;
            i_led_pump_host.wr(`LP_ADDR_GP, s[0] ? 8'h07 : 8'h01);
            i_led_pump_host.wr(`LP_ADDR_VFDLY, 8'(s));
            @(posedge CLK);
            // Odd passes: all groups on, only the indicator sink lacks headroom
            sink_low <= s[0] ? 10'h001 : 10'h010;
            repeat ((n - 1) * TICK - 1) @(posedge CLK);
            @(negedge CLK);
            chk("gain_early", 10'(gain_hi), 10'h000);
            t = 0;
            while (gain_hi !== 1'b1 && t < 2 * TICK + 10) begin
                @(negedge CLK);
                t++;
            end
            chk("gain_rise", 10'(gain_hi), 10'h001);
            i_led_pump_host.rd(`LP_ADDR_STATUS, d);
            chk("status", 10'(d), 10'h005);
            @(negedge CLK);
            chk("rdata_idle", 10'(rdata), 10'h000);
            @(posedge CLK);
            sink_low <= 10'h000;
            repeat (8) @(posedge CLK);
            @(negedge CLK);
            chk("gain_hold", 10'(gain_hi), 10'h001);
            i_led_pump_host.wr(`LP_ADDR_RAMP, 8'h5a);
            @(negedge CLK);
            chk("gain_reeval", 10'(gain_hi), 10'h000);
        end
        i_led_pump_host.rd(`LP_ADDR_RAMP, d);
        chk("ramp_read", 10'(d), 10'h05a);
        $display("gain_check done");
    endtask

    task automatic thermal_check();
        @(posedge CLK);
        temp_hot <= 1'b1;
        repeat (4) @(posedge CLK);
        @(negedge CLK);
        chk("shut_on", 10'(shut), 10'h001);
        chk("shut_sinks", sink_en, 10'h000);
        chk("shut_pump", 10'(pump_en), 10'h000);
        @(posedge CLK);
        temp_hot <= 1'b0;
        temp_cool <= 1'b1;
        repeat (4) @(posedge CLK);
        @(negedge CLK);
        chk("shut_off", 10'(shut), 10'h000);
        chk("resume_sinks", sink_en, 10'h3ff);
        temp_cool <= 1'b0;
        $display("thermal_check done");
    endtask

    task automatic pin_check();
        logic [7:0] d;
        i_led_pump_host.set_pin(1'b0);
        repeat (4) @(posedge CLK);
        i_led_pump_host.wr(`LP_ADDR_GP, 8'h07);
        i_led_pump_host.rd(`LP_ADDR_GP, d);
        chk("pin_low_read", 10'(d), 10'h000);
        chk("pin_low_sinks", sink_en, 10'h000);
        i_led_pump_host.set_pin(1'b1);
        repeat (3) @(posedge CLK);
        i_led_pump_host.rd(`LP_ADDR_LVL_A, d);
        chk("pin_lvl_a", 10'(d), 10'(`LP_RST_LVL_A));
        chk("pin_main", 10'(main_lvl), 10'h000);
        chk("pin_gain", 10'(gain_hi), 10'h000);
        $display("pin_check done");
    endtask

    initial begin
        CLK = 1'b0;
        RST = 1'b1;
        sink_low = '0;
        temp_hot = 1'b0;
        temp_cool = 1'b0;
        repeat (20) @(posedge CLK);
        RST <= 1'b0;
        // The enable pin needs two synchroniser edges before requests count
        repeat (3) @(posedge CLK);
        reset_check();
        enable_check();
        level_check();
        gain_check();
        thermal_check();
        pin_check();
        test_done();
    end
endmodule
